/* pc_sequencer.sv */
// Program counter sequencer with two-stage fetch and execute pipeline.
module pc_sequencer
  import pcseq_pkg::*;
(
  // Clock and reset
  input  wire logic              clk_sys,
  input  wire logic              sys_rst,
  // Program memory
  output logic [PC_W-1:0]        rom_addr,
  input  wire logic [WORD_W-1:0] rom_data,
  // Table lookup
  input  wire logic              tbl_rd,
  input  wire logic [PC_W-1:0]   table_pointer,
  output logic [WORD_W-1:0]      tbl_data,
  output logic                   tbl_valid,
  // Execute stage
  output logic [WORD_W-1:0]      exec_instr,
  output logic                   exec_valid,
  output logic [PC_W-1:0]        exec_pc,
  input  wire flow_cmd_s         flow,
  output logic [LOW_W-1:0]       pc_low_byte,
  output logic [PC_W-1:0]        ret_addr,
  // Stack and interrupts
  input  wire logic [PC_W-1:0]   stack_top,
  input  wire vec_req_s          vec_req,
  output logic                   vec_ack,
  // Phase
  output phase_e                 phase,
  output logic                   cyc_end
);
  logic [PC_W-1:0]   pc_q;
  logic [PC_W-1:0]   pc_d;
  logic [WORD_W-1:0] ir_q;
  logic [WORD_W-1:0] ir_d;
  logic              iv_q;
  logic              iv_d;
  logic [PC_W-1:0]   ipc_q;
  logic [PC_W-1:0]   ipc_d;
  logic [WORD_W-1:0] tb_q;
  logic [WORD_W-1:0] tb_d;
  logic              tv_q;
  logic              tv_d;
  logic              vack_q;
  logic              vack_d;
  logic              redirect;

  phase_gen u_phase (
    .clk_sys (clk_sys),
    .sys_rst (sys_rst),
    .phase   (phase),
    .cyc_end (cyc_end)
  );

  function automatic logic [PC_W-1:0] pc_inc(input logic [PC_W-1:0] v);
    pc_inc = v + PC_ONE;
  endfunction

  // ---------------------------------------------------------------
  // Fetch address mux
  // ---------------------------------------------------------------
  // Table reads borrow the memory only in phase two; fetch uses phase four.
  assign rom_addr = (phase == PH_2 && tbl_rd) ? table_pointer : pc_q;

  // ---------------------------------------------------------------
  // Counter and pipeline
  // ---------------------------------------------------------------
  always_comb begin
    pc_d     = pc_q;
    ir_d     = ir_q;
    iv_d     = iv_q;
    ipc_d    = ipc_q;
    tb_d     = tb_q;
    tv_d     = 1'b0;
    vack_d   = 1'b0;
    redirect = 1'b0;
    if (phase == PH_2 && tbl_rd) begin
      tb_d = rom_data;
      tv_d = 1'b1;
    end
    if (cyc_end) begin
      ir_d  = rom_data;
      ipc_d = pc_q;
      iv_d  = 1'b1;
      pc_d  = pc_inc(pc_q);
      // Return outranks every other command so a stacked address is kept.
      if (iv_q && flow.ret) begin
        pc_d = stack_top;
        redirect = 1'b1;
      end else if (iv_q && (flow.jump || flow.call)) begin
        pc_d = flow.target;
        redirect = 1'b1;
      end else if (iv_q && flow.low_wr) begin
        pc_d = {pc_q[PC_W-1:LOW_W], flow.low_data};
        redirect = 1'b1;
      end else if (iv_q && flow.skip) begin
        redirect = 1'b1;
      end else if (iv_q && |vec_req) begin
        // The acknowledge lets the arbiter push the return address.
        vack_d = 1'b1;
        redirect = 1'b1;
        if (vec_req.ext) begin
          pc_d = VEC_EXT;
        end else if (vec_req.tmr0) begin
          pc_d = VEC_TMR0;
        end else if (vec_req.tmr1) begin
          pc_d = VEC_TMR1;
        end else begin
          pc_d = VEC_ADC;
        end
      end
      // The prefetched word becomes a dummy cycle after any transfer.
      if (redirect) begin
        iv_d = 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      pc_q   <= VEC_RESET;
      ir_q   <= '0;
      iv_q   <= 1'b0;
      ipc_q  <= VEC_RESET;
      tb_q   <= '0;
      tv_q   <= 1'b0;
      vack_q <= 1'b0;
    end else begin
      pc_q   <= pc_d;
      ir_q   <= ir_d;
      iv_q   <= iv_d;
      ipc_q  <= ipc_d;
      tb_q   <= tb_d;
      tv_q   <= tv_d;
      vack_q <= vack_d;
    end
  end

  assign exec_instr  = ir_q;
  assign exec_valid  = iv_q;
  assign exec_pc     = ipc_q;
  assign pc_low_byte = pc_q[LOW_W-1:0];
  assign ret_addr    = pc_q;
  assign tbl_data    = tb_q;
  assign tbl_valid   = tv_q;
  assign vec_ack     = vack_q;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  a_pc_increment: assert property (@(posedge clk_sys) disable iff (sys_rst)
    cyc_end && !(iv_q && (flow.ret || flow.jump || flow.call || flow.low_wr
      || flow.skip || |vec_req)) |=> pc_q == $past(pc_q) + PC_ONE)
    else $error("Counter did not advance by one.");
  a_pc_hold: assert property (@(posedge clk_sys) disable iff (sys_rst)
    !cyc_end |=> pc_q == $past(pc_q))
    else $error("Counter changed mid cycle.");
  a_skip_dummy: assert property (@(posedge clk_sys) disable iff (sys_rst)
    cyc_end && iv_q && flow.skip |=> !iv_q ##4 iv_q)
    else $error("Skip did not insert one dummy cycle.");
  a_jump_target: assert property (@(posedge clk_sys) disable iff (sys_rst)
    cyc_end && iv_q && !flow.ret && (flow.jump || flow.call)
      |=> pc_q == $past(flow.target) && !iv_q)
    else $error("Jump target not loaded.");
  a_ret_target: assert property (@(posedge clk_sys) disable iff (sys_rst)
    cyc_end && iv_q && flow.ret |=> pc_q == $past(stack_top))
    else $error("Return address not loaded.");
  a_low_write: assert property (@(posedge clk_sys) disable iff (sys_rst)
    cyc_end && iv_q && flow.low_wr && !flow.ret && !flow.jump && !flow.call
      |=> pc_q == {$past(pc_q[PC_W-1:LOW_W]), $past(flow.low_data)})
    else $error("Low byte write wrong.");
  a_ext_vector: assert property (@(posedge clk_sys) disable iff (sys_rst)
    vack_q && $past(vec_req.ext) |-> pc_q == VEC_EXT)
    else $error("External vector wrong.");
  a_adc_vector: assert property (@(posedge clk_sys) disable iff (sys_rst)
    vack_q && $past(vec_req) == 4'h1 |-> pc_q == VEC_ADC)
    else $error("Converter vector wrong.");
  a_fetch_pc: assert property (@(posedge clk_sys) disable iff (sys_rst)
    cyc_end |=> exec_pc == $past(pc_q) && iv_q == !$past(redirect))
    else $error("Fetch pipeline mismatch.");
  a_ret_dummy: assert property (@(posedge clk_sys) disable iff (sys_rst)
    cyc_end && iv_q && flow.ret |=> !iv_q)
    else $error("Return did not insert a dummy cycle.");
  a_skip_target: assert property (@(posedge clk_sys) disable iff (sys_rst)
    cyc_end && iv_q && flow.skip && !(flow.ret || flow.jump || flow.call
      || flow.low_wr)
      |=> pc_q == $past(exec_pc) + PC_ONE + PC_ONE)
    else $error("Skip did not land two words on.");

  // ---------------------------------------------------------------
  // Vector and table checks
  // ---------------------------------------------------------------
  a_tmr0_vector: assert property (@(posedge clk_sys) disable iff (sys_rst)
    vack_q && $past(vec_req) == 4'h4 |-> pc_q == VEC_TMR0)
    else $error("First timer vector wrong.");
  a_tmr1_vector: assert property (@(posedge clk_sys) disable iff (sys_rst)
    vack_q && $past(vec_req) == 4'h2 |-> pc_q == VEC_TMR1)
    else $error("Second timer vector wrong.");
  a_vec_dummy: assert property (@(posedge clk_sys) disable iff (sys_rst)
    vack_q |-> !iv_q)
    else $error("Vector entry did not insert a dummy cycle.");
  a_vack_pulse: assert property (@(posedge clk_sys) disable iff (sys_rst)
    vack_q |=> !vack_q)
    else $error("Vector acknowledge longer than one cycle.");
  a_tbl_addr: assert property (@(posedge clk_sys) disable iff (sys_rst)
    phase == PH_2 && tbl_rd |-> rom_addr == table_pointer)
    else $error("Table read did not address the table pointer.");
  a_tbl_data: assert property (@(posedge clk_sys) disable iff (sys_rst)
    phase == PH_2 && tbl_rd
      |=> tbl_valid && tbl_data == $past(rom_data))
    else $error("Table word not returned.");

  // ---------------------------------------------------------------
  // Coverage
  // ---------------------------------------------------------------
  c_skip: cover property (@(posedge clk_sys) cyc_end && iv_q && flow.skip);
  c_ret:  cover property (@(posedge clk_sys) cyc_end && iv_q && flow.ret);
  c_jump: cover property (@(posedge clk_sys) cyc_end && iv_q && flow.jump);
  c_vec:  cover property (@(posedge clk_sys) vack_q);
  c_tbl:  cover property (@(posedge clk_sys) tv_q);
endmodule

/* pcseq_pkg.sv */
// Package of constants and types for the program counter sequencer.
// Functional notes
// - Four non-overlapping phases from system clock; instruction cycle is four clocks.
// - Fetch one instruction while the previous one executes; one per cycle.
// - Any counter-altering instruction takes two cycles using a dummy cycle.
// - Counter advances by one after each instruction fetch.
// - True skip discards prefetched instruction and runs a dummy cycle.
// - Low counter byte readable and writable; write keeps upper bits.
// - Counter loads target on jump, low write, call, reset, interrupt, return; skip advances by one.
// - Program memory is 4096 words of 15 bits, fetched or table read.
// - Fixed entry locations exist for reset and each interrupt source.
// - Reset clears the counter so execution starts at zero.
// - Accepted external interrupt loads the external entry address.
// - Accepted timer overflows load first or second timer entry address.
// - Accepted converter interrupt loads the converter entry address.
package pcseq_pkg;
  localparam int unsigned PC_W    = 12;
  localparam int unsigned WORD_W  = 15;
  localparam int unsigned LOW_W   = 8;
  localparam int unsigned PHASE_N = 4;
  localparam logic [11:0] VEC_RESET = 12'h000;
  localparam logic [11:0] VEC_EXT   = 12'h004;
  localparam logic [11:0] VEC_TMR0  = 12'h008;
  localparam logic [11:0] VEC_TMR1  = 12'h00c;
  localparam logic [11:0] VEC_ADC   = 12'h010;
  localparam logic [11:0] PC_ONE    = 12'h001;

  typedef enum logic [3:0] {
    PH_1 = 4'h1,
    PH_2 = 4'h2,
    PH_3 = 4'h4,
    PH_4 = 4'h8
  } phase_e;

  // Interrupt vector requests, highest priority first, from the arbiter.
  typedef struct packed {
    logic ext;
    logic tmr0;
    logic tmr1;
    logic adc;
  } vec_req_s;

  // Flow command from the execute stage, valid at end of a cycle.
  typedef struct packed {
    logic            jump;
    logic            call;
    logic            ret;
    logic            skip;
    logic            low_wr;
    logic [11:0]     target;
    logic [7:0]      low_data;
  } flow_cmd_s;
endpackage

/* phase_gen.sv */
// Four-phase generator dividing the system clock into instruction cycles.
module phase_gen
  import pcseq_pkg::*;
(
  // Clock and reset
  input  wire logic clk_sys,
  input  wire logic sys_rst,
  // Phases
  output phase_e    phase,
  output logic      cyc_end
);
  phase_e phase_q;
  phase_e phase_d;

  always_comb begin
    unique case (phase_q)
      PH_1: phase_d = PH_2;
      PH_2: phase_d = PH_3;
      PH_3: phase_d = PH_4;
      PH_4: phase_d = PH_1;
      default: phase_d = PH_1;
    endcase
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      phase_q <= PH_1;
    end else begin
      phase_q <= phase_d;
    end
  end

  assign phase   = phase_q;
  assign cyc_end = (phase_q == PH_4);

  a_phase_onehot: assert property (@(posedge clk_sys) disable iff (sys_rst)
    $onehot(phase_q))
    else $error("Phase is not one-hot.");
  a_phase_period: assert property (@(posedge clk_sys) disable iff (sys_rst)
    phase_q == PH_1 |-> ##4 phase_q == PH_1)
    else $error("Instruction cycle is not four clocks.");
endmodule

/* program_counter_sequencer_tb.sv */
// Self-checking bench for the program counter sequencer.
module program_counter_sequencer_tb
  import pcseq_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    flow_cmd_s   f;
    vec_req_s    v;
    logic [1:0]  m;
    logic [11:0] e;
  } row_s;
  logic              clk_sys, sys_rst, tbl_rd, tbl_valid;
  logic              exec_valid, vec_ack, cyc_end;
  logic [PC_W-1:0]   table_pointer, stack_top, rom_addr, exec_pc, ret_addr;
  logic [WORD_W-1:0] rom_data, tbl_data, exec_instr;
  logic [LOW_W-1:0]  pc_low_byte;
  flow_cmd_s         flow;
  vec_req_s          vec_req;
  phase_e            phase;
  int                miscompares, checks_done;
  // Mode 0 absolute, 1 next word, 2 two words on, 3 low byte replaced.
  row_s rows[15] = '{
    {5'h00, 12'h000, 8'h00, 4'h0, 2'd1, 12'h000},
    {5'h10, 12'h3f0, 8'h00, 4'h0, 2'd0, 12'h3f0},
    {5'h08, 12'h7a5, 8'h00, 4'h0, 2'd0, 12'h7a5},
    {5'h04, 12'h000, 8'h00, 4'h0, 2'd0, 12'h123},
    {5'h02, 12'h000, 8'h00, 4'h0, 2'd2, 12'h000},
    {5'h01, 12'h000, 8'h40, 4'h0, 2'd3, 12'h040},
    {5'h00, 12'h000, 8'h00, 4'h8, 2'd0, VEC_EXT},
    {5'h00, 12'h000, 8'h00, 4'h4, 2'd0, VEC_TMR0},
    {5'h00, 12'h000, 8'h00, 4'h2, 2'd0, VEC_TMR1},
    {5'h00, 12'h000, 8'h00, 4'h1, 2'd0, VEC_ADC},
    {5'h00, 12'h000, 8'h00, 4'h9, 2'd0, VEC_EXT},
    {5'h14, 12'h3f0, 8'h00, 4'h0, 2'd0, 12'h123},
    {5'h10, 12'hffe, 8'h00, 4'h0, 2'd0, 12'hffe},
    {5'h00, 12'h000, 8'h00, 4'h0, 2'd1, 12'h000},
    {5'h00, 12'h000, 8'h00, 4'h0, 2'd1, 12'h000}
  };
  pc_sequencer i_pc_sequencer (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .rom_addr(rom_addr),
    .rom_data(rom_data), .tbl_rd(tbl_rd), .table_pointer(table_pointer),
    .tbl_data(tbl_data), .tbl_valid(tbl_valid), .exec_instr(exec_instr),
    .exec_valid(exec_valid), .exec_pc(exec_pc), .flow(flow),
    .pc_low_byte(pc_low_byte), .ret_addr(ret_addr), .stack_top(stack_top),
    .vec_req(vec_req), .vec_ack(vec_ack), .phase(phase), .cyc_end(cyc_end)
  );
  rom_model i_rom_model (.rom_addr(rom_addr), .rom_data(rom_data));
  // --------------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------------
  task automatic cmp_val(input string nm, input logic [14:0] e, g);
    checks_done++;
    if (g !== e) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic cmp_bit(input string nm, input logic e, g);
    checks_done++;
    if (g !== e) begin
      miscompares++;
      $display("BAD %s expected %b seen %b", nm, e, g);
    end
  endtask
  task automatic close_out();
    $display("checks %0d miscompares %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic tick();
    @(posedge clk_sys);
    #1;
  endtask
  task automatic to_ph4();
    int n;
    n = 0;
    do begin
      tick();
      n++;
    end while (phase !== PH_4 && n < 8);
  endtask
  task automatic to_valid(output int d);
    d = 0;
    to_ph4();
    while (exec_valid !== 1'b1 && d < 4) begin
      d++;
      to_ph4();
    end
  endtask
  task automatic do_reset(input int n);
    int d;
    sys_rst = 1'b1;
    repeat (n) tick();
    cmp_bit("exec_valid", 1'b0, exec_valid);
    cmp_val("phase", 15'(PH_1), 15'(phase));
    cmp_val("ret_addr", 15'(VEC_RESET), 15'(ret_addr));
    sys_rst = 1'b0;
    to_valid(d);
    cmp_val("exec_pc", 15'(VEC_RESET), 15'(exec_pc));
  endtask
  // Issues one command at a valid phase 4 and checks where flow lands.
  task automatic go(input row_s r);
    logic [11:0] nx, ex;
    int          d;
    nx = exec_pc + PC_ONE;
    cmp_val("ret_addr", 15'(nx), 15'(ret_addr));
    cmp_val("rom_addr", 15'(nx), 15'(rom_addr));
    cmp_val("pc_low_byte", 15'(nx[7:0]), 15'(pc_low_byte));
    ex = r.m == 2'd1 ? nx : r.m == 2'd2 ? nx + PC_ONE :
         r.m == 2'd3 ? {nx[11:8], r.e[7:0]} : r.e;
    flow = r.f;
    vec_req = r.v;
    tick();
    flow = '0;
    vec_req = '0;
    cmp_bit("vec_ack", |r.v, vec_ack);
    to_valid(d);
    cmp_val("dummy", 15'(r.m != 2'd1), 15'(d));
    cmp_val("exec_pc", 15'(ex), 15'(exec_pc));
    cmp_val("exec_instr", {ex[2:0], ex}, exec_instr);
  endtask
  // --------------------------------------------------------------------
  // Stimulus
  // --------------------------------------------------------------------
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  initial begin
    #50000;
    miscompares++;
    close_out();
  end
  initial begin
    flow = '0;
    vec_req = '0;
    tbl_rd = 1'b0;
    table_pointer = '0;
    stack_top = 12'h123;
    sys_rst = 1'b1;
    miscompares = 0;
    checks_done = 0;
    do_reset(8);
    foreach (rows[i]) go(rows[i]);
    for (int i = 0; i < 4; i++) begin
      tick();
      cmp_val("phase", 15'(4'h1 << i), 15'(phase));
      cmp_bit("cyc_end", i == 3, cyc_end);
    end
    tick();
    tick();
    table_pointer = 12'h5a5;
    tbl_rd = 1'b1;
    tick();
    tbl_rd = 1'b0;
    cmp_bit("tbl_valid", 1'b1, tbl_valid);
    cmp_val("tbl_data", 15'h55a5, tbl_data);
    tick();
    cmp_bit("tbl_valid", 1'b0, tbl_valid);
    do_reset(3);
    close_out();
  end
endmodule

/* rom_model.sv */
// Program memory model answering fetches and table reads.
module rom_model
  import pcseq_pkg::*;
(
  // Program memory
  input  wire logic [PC_W-1:0]   rom_addr,
  output logic      [WORD_W-1:0] rom_data
);
  timeunit 1ns;
  timeprecision 1ps;
  // Each word holds its own address, so a wrong fetch shows in the data.
  assign rom_data = {rom_addr[2:0], rom_addr};
endmodule
